// File: rtl/ids_i2c_dac_slave.sv
// I2C slave front end that loads the converter code and power-down mode.
`timescale 1ns/1ps
`default_nettype none
module ids_i2c_dac_slave (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // I2C pins, open drain
  input  wire logic               sclIn,
  input  wire logic               sdaIn,
  output logic                    sdaOut,
  output logic                    sdaOe,
  input  wire logic               address_select_pin,
  // Converter side
  output var  ids_pkg::ids_dac_t  dacState,
  output logic                    high_speed_rate,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o
);
  import ids_pkg::*;

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    ids_state_t  state;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic        ackDrive;
    logic        isAddr;
    logic        byteIdx;
    logic [7:0]  msbByte;
    logic [7:0]  code;
    logic [1:0]  pdMode;
    logic        hsMode;
    logic        sdaOe;
    logic        sdaOut;
    logic        sclPrev;
    logic        sdaPrev;
    logic [1:0]  capCnt;
    logic        capDone;
    logic        addrSel;
    logic        slaveEnable;
    logic        wbAck;
    logic [31:0] wbDat;
  } ids_regs_t;

  ids_regs_t st;
  ids_regs_t next_st;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pinSync;
  logic       sclS;
  logic       sdaS;
  logic       selS;

  ids_sync #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .d       ({address_select_pin, sdaIn, sclIn}),
    .q       (pinSync)
  );

  assign sclS = pinSync[0];
  assign sdaS = pinSync[1];
  assign selS = pinSync[2];

  // ****************************************************************
  // Bus condition decode
  // ****************************************************************
  // SCL is only ever sampled; the master owns every clock pulse.
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic byteDone;
  logic ownMatch;
  logic bcastMatch;
  logic masterCode;

  assign sclRise    = sclS & ~st.sclPrev;
  assign sclFall    = ~sclS & st.sclPrev;
  assign startCond  = sclS & st.sclPrev & st.sdaPrev & ~sdaS;
  assign stopCond   = sclS & st.sclPrev & ~st.sdaPrev & sdaS;
  assign byteDone   = sclFall && (st.bitCnt == BITS_PER_BYTE);
  assign ownMatch   = (st.shift[7:1] == {ADDR_FIXED, st.addrSel}) && !st.shift[0];
  assign bcastMatch = (st.shift == BCAST_BYTE);
  assign masterCode = (st.shift[7:3] == MASTER_CODE);

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;
  logic        addressed;

  assign addressed = (st.state == ST_DATA) || (st.state == ST_ACK && !st.isAddr);

  always_comb begin
    ctrlWord = '0;
    ctrlWord[CTRL_EN_BIT] = st.slaveEnable;
    statusWord = '0;
    statusWord[ST_CODE_LSB +: 8] = st.code;
    statusWord[ST_PD_LSB +: 2] = st.pdMode;
    statusWord[ST_HS_BIT] = st.hsMode;
    statusWord[ST_ADDRD_BIT] = addressed;
    statusWord[ST_SEL_BIT] = st.addrSel;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.sclPrev = sclS;
    next_st.sdaPrev = sdaS;
    // The pin is only ever pulled low, never driven high.
    next_st.sdaOut = 1'b0;

    // The select pin is caught once, after reset and after the synchroniser settles.
    if (!st.capDone) begin
      if (st.capCnt == CAP_CYCLES) begin
        next_st.addrSel = selS;
        next_st.capDone = 1'b1;
      end else begin
        next_st.capCnt = st.capCnt + 2'h1;
      end
    end

    // Wishbone: ack one cycle after the strobe; the write lands on the ack edge.
    next_st.wbAck = wb_cyc_i & wb_stb_i & ~st.wbAck;
    if (wb_cyc_i && wb_stb_i && !st.wbAck) begin
      if (wb_adr_i == OFF_CTRL) begin
        next_st.wbDat = ctrlWord;
      end else if (wb_adr_i == OFF_STATUS) begin
        next_st.wbDat = statusWord;
      end else begin
        next_st.wbDat = '0;
      end
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && st.wbAck && wb_sel_i[0] && wb_adr_i == OFF_CTRL) begin
      next_st.slaveEnable = wb_dat_i[CTRL_EN_BIT];
    end

    if (stopCond) begin
      next_st.state  = ST_IDLE;
      next_st.sdaOe  = 1'b0;
      next_st.hsMode = 1'b0;
    end else if (startCond) begin
      // A repeated start takes this same path and keeps the rate setting.
      next_st.state   = (st.slaveEnable && st.capDone) ? ST_ADDR : ST_IDLE;
      next_st.bitCnt  = '0;
      next_st.sdaOe   = 1'b0;
      next_st.byteIdx = 1'b0;
    end else begin
      case (st.state)
        ST_IDLE: begin
          // Traffic is ignored until the next start condition.
          next_st.sdaOe = 1'b0;
        end
        ST_ADDR, ST_DATA: begin
          // SDA is sampled on the rising SCL edge, the stable high phase.
          if (sclRise && st.bitCnt < BITS_PER_BYTE) begin
            next_st.shift  = {st.shift[6:0], sdaS};
            next_st.bitCnt = st.bitCnt + 4'h1;
          end else if (byteDone) begin
            next_st.state  = ST_ACK;
            next_st.bitCnt = '0;
            next_st.isAddr = (st.state == ST_ADDR);
            if (st.state == ST_ADDR) begin
              // Read direction, ten-bit and general call bytes match nothing.
              next_st.ackDrive = ownMatch | bcastMatch;
              if (masterCode) begin
                next_st.hsMode = 1'b1;
              end
            end else begin
              next_st.ackDrive = 1'b1;
              if (!st.byteIdx) begin
                next_st.msbByte = st.shift;
              end
            end
            next_st.sdaOe = next_st.ackDrive;
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            next_st.sdaOe = 1'b0;
            if (st.ackDrive) begin
              next_st.state = ST_DATA;
              if (!st.isAddr) begin
                if (st.byteIdx) begin
                  next_st.code   = {st.msbByte[3:0], st.shift[7:4]};
                  next_st.pdMode = st.msbByte[5:4];
                end
                next_st.byteIdx = ~st.byteIdx;
              end
            end else begin
              next_st.state = ST_IGNORE;
            end
          end
        end
        ST_IGNORE: begin
          next_st.sdaOe = 1'b0;
        end
        default: begin
          next_st.state = ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st             <= '0;
      st.state       <= ST_IDLE;
      st.code        <= CODE_RESET;
      st.pdMode      <= PD_NORMAL;
      st.sclPrev     <= 1'b1;
      st.sdaPrev     <= 1'b1;
      st.slaveEnable <= CTRL_EN_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sdaOut          = st.sdaOut;
  assign sdaOe           = st.sdaOe;
  assign dacState.code   = st.code;
  assign dacState.pdMode = st.pdMode;
  assign high_speed_rate = st.hsMode;
  assign wb_dat_o        = st.wbDat;
  assign wb_ack_o        = st.wbAck;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_start_addr;
    @(posedge sys_clk) disable iff (reset)
    (startCond && !stopCond && st.slaveEnable && st.capDone)
      |=> (st.state == ST_ADDR) && (st.bitCnt == 4'h0) && !st.sdaOe;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start did not open address");

  property p_stop_release;
    @(posedge sys_clk) disable iff (reset)
    stopCond |=> (st.state == ST_IDLE) && !st.sdaOe && !st.hsMode;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("stop did not release");

  property p_pull_low_only;
    @(posedge sys_clk) disable iff (reset)
    $rose(st.sdaOe) |-> !st.sdaOut && $past(sclFall) && (st.state == ST_ACK);
  endproperty
  a_pull_low_only: assert property (p_pull_low_only) else $error("bad SDA drive");

  property p_own_ack;
    @(posedge sys_clk) disable iff (reset)
    (st.state == ST_ADDR && byteDone && ownMatch && !startCond && !stopCond)
      |=> st.sdaOe ##1 (st.sdaOe || st.state != ST_ACK);
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("own address not acknowledged");

  property p_master_code;
    @(posedge sys_clk) disable iff (reset)
    (st.state == ST_ADDR && byteDone && masterCode && !startCond && !stopCond)
      |=> st.hsMode && !st.sdaOe;
  endproperty
  a_master_code: assert property (p_master_code) else $error("master code handling wrong");

  property p_no_read_ack;
    @(posedge sys_clk) disable iff (reset)
    (st.state == ST_ADDR && byteDone && st.shift[0]) |=> !st.sdaOe;
  endproperty
  a_no_read_ack: assert property (p_no_read_ack) else $error("read address acknowledged");

  property p_bcast_ack;
    @(posedge sys_clk) disable iff (reset)
    (st.state == ST_ADDR && byteDone && bcastMatch && !startCond && !stopCond) |=> st.sdaOe;
  endproperty
  a_bcast_ack: assert property (p_bcast_ack) else $error("broadcast not acknowledged");

  property p_gencall;
    @(posedge sys_clk) disable iff (reset)
    (st.state == ST_ADDR && byteDone && st.shift == 8'h00) |=> !st.sdaOe;
  endproperty
  a_gencall: assert property (p_gencall) else $error("general call acknowledged");

  property p_update;
    @(posedge sys_clk) disable iff (reset)
    (st.state == ST_ACK && sclFall && st.ackDrive && !st.isAddr && st.byteIdx
      && !startCond && !stopCond)
      |=> (st.code[7:4] == $past(st.msbByte[3:0])) && (st.code[3:0] == $past(st.shift[7:4]))
          && (st.pdMode == $past(st.msbByte[5:4]));
  endproperty
  a_update: assert property (p_update) else $error("code not loaded");

  property p_code_hold;
    @(posedge sys_clk) disable iff (reset)
    (st.state != ST_ACK) |=> $stable(st.code) && $stable(st.pdMode);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed outside update");

  property p_wb_ack;
    @(posedge sys_clk) disable iff (reset)
    (wb_cyc_i && wb_stb_i && !st.wbAck) |=> st.wbAck ##1 !st.wbAck;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack timing wrong");

endmodule
`default_nettype wire

// File: rtl/ids_pkg.sv
// Shared constants and types of the I2C converter slave front end.
package ids_pkg;

  // ****************************************************************
  // Register map on the Wishbone slave
  // ****************************************************************
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam int          CTRL_EN_BIT   = 0;
  localparam logic        CTRL_EN_RESET = 1'b1;
  localparam int          ST_CODE_LSB   = 0;
  localparam int          ST_PD_LSB     = 8;
  localparam int          ST_HS_BIT     = 10;
  localparam int          ST_ADDRD_BIT  = 11;
  localparam int          ST_SEL_BIT    = 12;

  // ****************************************************************
  // Bus protocol constants
  // ****************************************************************
  localparam logic [5:0]  ADDR_FIXED    = 6'h26;
  localparam logic [7:0]  BCAST_BYTE    = 8'h90;
  localparam logic [4:0]  MASTER_CODE   = 5'h01;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic [7:0]  CODE_RESET    = 8'h00;
  localparam logic [1:0]  PD_NORMAL     = 2'h0;
  localparam int          SYNC_STAGES   = 2;
  localparam logic [1:0]  CAP_CYCLES    = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_ACK,
    ST_IGNORE
  } ids_state_t;

  typedef struct packed {
    logic [1:0] pdMode;
    logic [7:0] code;
  } ids_dac_t;

endpackage

// File: rtl/ids_sync.sv
// Two-stage synchroniser for inputs from outside the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module ids_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [1:0][WIDTH-1:0] stages;
  logic [1:0][WIDTH-1:0] next_stages;

  // The first stage feeds only the second stage.
  always_comb begin
    next_stages[0] = d;
    next_stages[1] = stages[0];
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stages <= '1;
    end else begin
      stages <= next_stages;
    end
  end

  assign q = stages[1];

endmodule
`default_nettype wire

// File: tb/ids_i2c_master.sv
// Behavioural I2C bus master that drives SCL and pulls SDA low.
`timescale 1ns/1ps
`default_nettype none
module ids_i2c_master (
  // Bus lines
  output logic      scl,
  output logic      sdaPull,
  input  wire logic sdaWire
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  // Also serves as a repeated start when entered with SCL low.
  // Lines change by non-blocking assignment, so a change that meets a system clock edge is
  // still sampled cleanly by the slave's synchronisers.
  task automatic start(input int h);
    sdaPull <= 1'b0;
    #(h/2) scl <= 1'b1;
    #h sdaPull <= 1'b1;
    #h scl <= 1'b0;
    #(h/2);
  endtask

  task automatic stop(input int h);
    sdaPull <= 1'b1;
    #(h/2) scl <= 1'b1;
    #h sdaPull <= 1'b0;
    #h;
  endtask

  // The acknowledge is sampled early and late in the high phase.
  task automatic sendByte(input logic [7:0] b, input int h, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaPull <= !b[i];
      #(h/2) scl <= 1'b1;
      #h scl <= 1'b0;
      #(h/2);
    end
    sdaPull <= 1'b0;
    #(h/2) scl <= 1'b1;
    #(h/4) ack = !sdaWire;
    #(h/2) ack = ack & !sdaWire;
    #(h/4) scl <= 1'b0;
    #(h/2);
  endtask
endmodule
`default_nettype wire

// File: tb/ids_i2c_dac_slave_bench.sv
// Self-checking bench of the I2C converter slave front end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module ids_i2c_dac_slave_bench;
  import ids_pkg::*;
  // Link half period of 24 ns; the master code goes at 400 kbps.
  localparam int H = 24;
  localparam int HS = 1250;
  logic        sys_clk, reset, scl, sdaPull, sdaWire, sdaOut, sdaOe;
  logic        a, cyc, stb, we, ack, hs;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rd, rdat;
  ids_dac_t    dac;
  logic [7:0]  bad [4] = '{8'h98, 8'h9B, 8'h00, 8'hF0};
  int          n_fail, checked;
  int          cycles = 0;

  // ****************************************************************
  // Clock, bus wiring, instances
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Open drain: the wire is pulled up unless a party enables a low drive.
  assign sdaWire = !sdaPull && (!sdaOe || sdaOut);

  ids_i2c_master i_master (.scl(scl), .sdaPull(sdaPull), .sdaWire(sdaWire));

  ids_i2c_dac_slave i_dut (
    .sys_clk(sys_clk), .reset(reset), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .address_select_pin(a), .dacState(dac),
    .high_speed_rate(hs), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic results();
    $display("Counts: checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      results();
    end
  end

  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    sel <= s;
    dat <= d;
    // No time-out of its own: if ack never comes, only the bench watchdog ends this wait.
    @(posedge sys_clk);
    while (ack !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wbr(input logic [7:0] ad, input logic [31:0] e);
    wb(1'b0, ad, 32'h0, 4'hF);
    `CHK("read data", e, rd)
  endtask

  task automatic tx(input logic [7:0] b, input int h, input logic e);
    logic k;
    i_master.sendByte(b, h, k);
    `CHK("acknowledge", e, k)
  endtask

  task automatic settle(input string nm);
    repeat (10) @(posedge sys_clk);
    $display("Test done: %s", nm);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    reset = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0;
    a = 1'b1;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (20) @(posedge sys_clk);
    `CHK("dac", 10'h000, dac)
    `CHK("hs", 1'b0, hs)
    wbr(OFF_CTRL, 32'h1);
    wbr(OFF_STATUS, 32'h1000);
    wbr(8'h08, 32'h0);
    settle("reset");
    i_master.start(H);
    tx(8'h9A, H, 1'b1);
    tx(8'h1A, H, 1'b1);
    tx(8'h5F, H, 1'b1);
    repeat (10) @(posedge sys_clk);
    `CHK("dac", 10'h1A5, dac)
    wbr(OFF_STATUS, 32'h19A5);
    tx(8'h3F, H, 1'b1);
    tx(8'h00, H, 1'b1);
    tx(8'h00, H, 1'b1);
    i_master.stop(H);
    settle("write");
    `CHK("dac", 10'h3F0, dac)
    `CHK("sdaOut", 1'b0, sdaOut)
    wbr(OFF_STATUS, 32'h13F0);
    foreach (bad[i]) begin
      i_master.start(H);
      tx(bad[i], H, 1'b0);
      tx(8'h00, H, 1'b0);
      tx(8'h00, H, 1'b0);
      i_master.stop(H);
    end
    settle("refused");
    `CHK("dac", 10'h3F0, dac)
    i_master.start(H);
    tx(BCAST_BYTE, H, 1'b1);
    tx(8'h00, H, 1'b1);
    tx(8'h10, H, 1'b1);
    i_master.stop(H);
    settle("broadcast");
    `CHK("dac", 10'h001, dac)
    i_master.start(HS);
    tx(8'h09, HS, 1'b0);
    `CHK("hs", 1'b1, hs)
    i_master.start(H);
    tx(8'h9A, H, 1'b1);
    tx(8'h2C, H, 1'b1);
    tx(8'hD0, H, 1'b1);
    i_master.start(H);
    tx(8'h9A, H, 1'b1);
    `CHK("dac", 10'h2CD, dac)
    tx(8'h07, H, 1'b1);
    tx(8'hE0, H, 1'b1);
    `CHK("hs", 1'b1, hs)
    wbr(OFF_STATUS, 32'h1C7E);
    i_master.stop(H);
    settle("high speed");
    `CHK("hs", 1'b0, hs)
    `CHK("dac", 10'h07E, dac)
    wb(1'b1, OFF_CTRL, 32'h0, 4'hE);
    wbr(OFF_CTRL, 32'h1);
    wb(1'b1, OFF_CTRL, 32'h0, 4'hF);
    wbr(OFF_CTRL, 32'h0);
    i_master.start(H);
    tx(8'h9A, H, 1'b0);
    i_master.stop(H);
    wb(1'b1, OFF_CTRL, 32'h1, 4'hF);
    i_master.start(H);
    tx(8'h9A, H, 1'b1);
    i_master.stop(H);
    settle("enable");
    results();
  end
endmodule
`default_nettype wire
